// >>> phsp_status.sv
// processor-hot status register and pulse output logic
`timescale 1ns/1ps
module phsp_status
	import phsp_pkg::*;
#(
	parameter int W0_CYC = PHSP_W0_CYC,
	parameter int W1_CYC = PHSP_W1_CYC,
	parameter int W2_CYC = PHSP_W2_CYC,
	parameter int W3_CYC = PHSP_W3_CYC,
	parameter int VAP_FAIL_LIMIT = PHSP_VAP_FAIL_LIMIT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire phsp_req_t reg_req,
	output logic [15:0] reg_rd_data,
	input wire phsp_trig_t trig_pins,
	input wire logic input_voltage_limit_pin,
	input wire logic thermal_shutdown_pin,
	input wire phsp_fault_t fault_pins,
	input wire logic input_voltage_profile_en,
	input wire logic peak_assist_req,
	input wire logic vap_load_attempt,
	input wire logic vap_load_fail,
	output logic peak_assist_mode,
	output logic processor_hot_out_n
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	initial begin
		if (W0_CYC < 1 || W1_CYC < 1 || W2_CYC < 1 || W3_CYC < 1)
			$error("phsp_status: pulse widths must be at least one cycle");
		if (W3_CYC >= (1 << PHSP_CNT_W) || W2_CYC >= (1 << PHSP_CNT_W))
			$error("phsp_status: pulse width exceeds timer range");
		if (VAP_FAIL_LIMIT < 1 || VAP_FAIL_LIMIT >= (1 << PHSP_VAP_CNT_W))
			$error("phsp_status: failure limit out of counter range");
	end

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// width field to minimum low time in cycles
	function automatic logic [PHSP_CNT_W-1:0] width_cycles(input logic [1:0] code);
		logic [PHSP_CNT_W-1:0] val;
		case (code)
			2'h0: val = PHSP_CNT_W'(W0_CYC);
			2'h1: val = PHSP_CNT_W'(W1_CYC);
			2'h2: val = PHSP_CNT_W'(W2_CYC);
			default: val = PHSP_CNT_W'(W3_CYC);
		endcase
		return val;
	endfunction : width_cycles

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int SYNC_W = 14;

	logic [SYNC_W-1:0] sync_a_r;
	logic [SYNC_W-1:0] sync_b_r;
	logic [SYNC_W-1:0] sync_a_nxt;
	logic [SYNC_W-1:0] sync_b_nxt;

	always_comb begin
		sync_a_nxt = {trig_pins, input_voltage_limit_pin, thermal_shutdown_pin, fault_pins};
		sync_b_nxt = sync_a_r;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a_r <= '0;
			sync_b_r <= '0;
		end else if (clk_en) begin
			sync_a_r <= sync_a_nxt;
			sync_b_r <= sync_b_nxt;
		end
	end

	phsp_trig_t trig_s;
	phsp_fault_t fault_s;
	logic vin_lim_s;
	logic thermal_shutdown_flag_s;
	logic trig_any;
	logic fault_any;

	assign trig_s = phsp_trig_t'(sync_b_r[13:7]);
	assign vin_lim_s = sync_b_r[6];
	assign thermal_shutdown_flag_s = sync_b_r[5];
	assign fault_s = phsp_fault_t'(sync_b_r[4:0]);
	assign trig_any = (|trig_s) | vin_lim_s;
	assign fault_any = |fault_s;

	// ---------------------------------------------------------------
	// register access decode
	// ---------------------------------------------------------------
	logic wr_hit;
	logic rd_hit;

	assign wr_hit = reg_req.wr_en && (reg_req.addr == PHSP_STATUS_ADDR);
	assign rd_hit = reg_req.rd_en && (reg_req.addr == PHSP_STATUS_ADDR);

	// ---------------------------------------------------------------
	// peak-assist supervision
	// ---------------------------------------------------------------
	logic [PHSP_VAP_CNT_W-1:0] vap_cnt_r;
	logic [PHSP_VAP_CNT_W-1:0] vap_cnt_nxt;
	logic vap_mode_r;
	logic vap_mode_nxt;
	logic vap_fail_evt;
	logic vap_exit_evt;
	logic [10:0] flag_r;

	always_comb begin
		vap_cnt_nxt = vap_cnt_r;
		vap_fail_evt = 1'b0;
		if (vap_mode_r && vap_load_attempt) begin
			if (!vap_load_fail) begin
				vap_cnt_nxt = '0;
			end else if (vap_cnt_r == PHSP_VAP_CNT_W'(VAP_FAIL_LIMIT - 1)) begin
				vap_fail_evt = 1'b1;
				vap_cnt_nxt = '0;
			end else begin
				vap_cnt_nxt = vap_cnt_r + PHSP_VAP_CNT_W'(1);
			end
		end
		// stays off while the failure flag is latched
		vap_mode_nxt = peak_assist_req && !flag_r[PHSP_BIT_VAP_FAIL] && !vap_fail_evt
			&& !fault_any;
		// exit by host disable or fault; a failure exit is reported on its own bit
		vap_exit_evt = vap_mode_r && !vap_mode_nxt && !vap_fail_evt;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vap_cnt_r <= '0;
			vap_mode_r <= 1'b0;
		end else if (clk_en) begin
			vap_cnt_r <= vap_cnt_nxt;
			vap_mode_r <= vap_mode_nxt;
		end
	end

	assign peak_assist_mode = vap_mode_r;

	// ---------------------------------------------------------------
	// status flags and read snapshot
	// ---------------------------------------------------------------
	logic [10:0] flag_nxt;
	logic [10:0] flag_set;
	logic [10:0] flag_clr;
	logic [15:0] snap_r;
	logic [15:0] snap_nxt;
	logic rd_pend_r;
	logic rd_pend_nxt;
	logic ext_en_r;
	logic ext_en_nxt;
	logic [1:0] width_r;
	logic [1:0] width_nxt;
	logic clear_r;
	logic clear_nxt;

	always_comb begin
		flag_set = '0;
		flag_set[PHSP_BIT_THERMAL_SHUTDOWN_FLAG] = thermal_shutdown_flag_s;
		flag_set[PHSP_BIT_VAP_FAIL] = vap_fail_evt;
		flag_set[PHSP_BIT_VAP_EXIT] = vap_exit_evt;
		flag_set[PHSP_BIT_VIN_LIM] = vin_lim_s && input_voltage_profile_en;
		flag_set[6:0] = trig_s;

		// only bits seen as one by the finished read are cleared
		flag_clr = '0;
		if (rd_pend_r && reg_req.rd_done)
			flag_clr = snap_r[10:0] & PHSP_RC_MASK;
		if (wr_hit)
			flag_clr = flag_clr | (~reg_req.wr_data[10:0] & PHSP_WC_MASK);

		// a new event in the clearing cycle survives
		flag_nxt = (flag_r & ~flag_clr) | flag_set;

		ext_en_nxt = ext_en_r;
		width_nxt = width_r;
		// bit 11 reads idle again one cycle after a clear was written
		clear_nxt = PHSP_RST_CLEAR;
		if (wr_hit) begin
			ext_en_nxt = reg_req.wr_data[PHSP_BIT_EXT_EN];
			width_nxt = reg_req.wr_data[PHSP_BIT_WIDTH_HI:PHSP_BIT_WIDTH_LO];
			clear_nxt = reg_req.wr_data[PHSP_BIT_CLEAR];
		end

		snap_nxt = snap_r;
		rd_pend_nxt = rd_pend_r;
		if (rd_hit) begin
			snap_nxt = {PHSP_RST_RSVD, ext_en_r, width_r, clear_r, flag_r};
			rd_pend_nxt = 1'b1;
		end else if (reg_req.rd_en) begin
			// unmapped address reads as zero and clears nothing
			snap_nxt = '0;
			rd_pend_nxt = 1'b0;
		end else if (reg_req.rd_done) begin
			rd_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= PHSP_RST_FLAGS;
			ext_en_r <= PHSP_RST_EXT_EN;
			width_r <= PHSP_RST_WIDTH;
			clear_r <= PHSP_RST_CLEAR;
			snap_r <= PHSP_STATUS_RST;
			rd_pend_r <= 1'b0;
		end else if (clk_en) begin
			flag_r <= flag_nxt;
			ext_en_r <= ext_en_nxt;
			width_r <= width_nxt;
			clear_r <= clear_nxt;
			snap_r <= snap_nxt;
			rd_pend_r <= rd_pend_nxt;
		end
	end

	assign reg_rd_data = snap_r;

	// ---------------------------------------------------------------
	// processor-hot output
	// ---------------------------------------------------------------
	logic timer_start;
	logic timer_busy;
	logic ext_hold_r;
	logic ext_hold_nxt;
	logic hot_low_r;
	logic hot_low_nxt;

	// the timer restarts while a trigger stays high, so the width counts from its end
	assign timer_start = trig_any && !ext_en_r;

	phsp_pulse_timer #(
		.CNT_W(PHSP_CNT_W)
	) u_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(timer_start),
		.load_val(width_cycles(width_r)),
		.busy(timer_busy)
	);

	always_comb begin
		// clear wins unless extension is enabled and a trigger is present in the same cycle
		ext_hold_nxt = (ext_hold_r && clear_r) || (ext_en_r && trig_any);
		if (!ext_en_r && !trig_any)
			ext_hold_nxt = ext_hold_r && clear_r;
		hot_low_nxt = trig_any
			|| ext_hold_r
			|| (!ext_en_r && timer_busy)
			|| flag_r[PHSP_BIT_VAP_EXIT]
			|| (flag_r[PHSP_BIT_VIN_LIM] && input_voltage_profile_en);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_hold_r <= 1'b0;
			hot_low_r <= 1'b0;
		end else if (clk_en) begin
			ext_hold_r <= ext_hold_nxt;
			hot_low_r <= hot_low_nxt;
		end
	end

	assign processor_hot_out_n = !hot_low_r;

endmodule : phsp_status

// >>> phsp_pkg.sv
// package with register layout, timing constants and carrier types for the processor-hot block
package phsp_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] PHSP_STATUS_ADDR = 8'h21;
	localparam logic [15:0] PHSP_STATUS_RST = 16'hB800;

	localparam int PHSP_BIT_RSVD = 15;
	localparam int PHSP_BIT_EXT_EN = 14;
	localparam int PHSP_BIT_WIDTH_HI = 13;
	localparam int PHSP_BIT_WIDTH_LO = 12;
	localparam int PHSP_BIT_CLEAR = 11;
	localparam int PHSP_BIT_THERMAL_SHUTDOWN_FLAG = 10;
	localparam int PHSP_BIT_VAP_FAIL = 9;
	localparam int PHSP_BIT_VAP_EXIT = 8;
	localparam int PHSP_BIT_VIN_LIM = 7;

	localparam logic PHSP_RST_RSVD = 1'b1;
	localparam logic PHSP_RST_EXT_EN = 1'b0;
	localparam logic [1:0] PHSP_RST_WIDTH = 2'h3;
	localparam logic PHSP_RST_CLEAR = 1'b1;
	localparam logic [10:0] PHSP_RST_FLAGS = 11'h000;

	// flags cleared by a completed read: bits 10 and 6:0
	localparam logic [10:0] PHSP_RC_MASK = 11'h47F;
	// flags cleared by writing zero: bits 9, 8 and 7
	localparam logic [10:0] PHSP_WC_MASK = 11'h380;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int PHSP_CLK_MHZ = 125;
	localparam int PHSP_T_W0_US = 100;
	localparam int PHSP_T_W1_US = 1000;
	localparam int PHSP_T_W2_US = 5000;
	localparam int PHSP_T_W3_US = 10000;
	localparam int PHSP_W0_CYC = PHSP_T_W0_US * PHSP_CLK_MHZ;
	localparam int PHSP_W1_CYC = PHSP_T_W1_US * PHSP_CLK_MHZ;
	localparam int PHSP_W2_CYC = PHSP_T_W2_US * PHSP_CLK_MHZ;
	localparam int PHSP_W3_CYC = PHSP_T_W3_US * PHSP_CLK_MHZ;
	localparam int PHSP_CNT_W = 21;

	localparam int PHSP_VAP_FAIL_LIMIT = 7;
	localparam int PHSP_VAP_CNT_W = 3;

	// ---------------------------------------------------------------
	// carrier types
	// ---------------------------------------------------------------
	// ordered so that the packed value lines up with status bits 6:0
	typedef struct packed {
		logic comparator_output;
		logic critical_current;
		logic nominal_current;
		logic discharge_level1;
		logic system_voltage;
		logic battery_removal;
		logic adapter_removal;
	} phsp_trig_t;

	typedef struct packed {
		logic input_overvoltage_fault;
		logic input_overcurrent_fault;
		logic system_overvoltage_fault;
		logic battery_overvoltage_fault;
		logic system_undervoltage_fault;
	} phsp_fault_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr_en;
		logic [15:0] wr_data;
		logic rd_en;
		logic rd_done;
	} phsp_req_t;

endpackage : phsp_pkg

// >>> phsp_pulse_timer.sv
// minimum-width timer for the processor-hot low pulse
`timescale 1ns/1ps
module phsp_pulse_timer
	import phsp_pkg::*;
#(
	parameter int CNT_W = PHSP_CNT_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic start,
	input wire logic [CNT_W-1:0] load_val,
	output logic busy
);

	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;

	initial begin
		if (CNT_W < 2)
			$error("phsp_pulse_timer: counter too narrow");
	end

	// the start cycle itself is already low, so one cycle is taken off
	always_comb begin
		count_nxt = count_r;
		if (start)
			count_nxt = load_val - CNT_W'(1);
		else if (count_r != '0)
			count_nxt = count_r - CNT_W'(1);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			count_r <= '0;
		else if (clk_en)
			count_r <= count_nxt;
	end

	assign busy = (count_r != '0);

endmodule : phsp_pulse_timer

// >>> phsp_status_properties.sv
// checker with the port-level register and timing properties of the processor-hot status block
`timescale 1ns/1ps
module phsp_status_properties
	import phsp_pkg::*;
#(
	parameter int W0_CYC = PHSP_W0_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire phsp_req_t reg_req,
	input wire logic [15:0] reg_rd_data,
	input wire phsp_trig_t trig_pins,
	input wire logic peak_assist_req,
	input wire logic peak_assist_mode,
	input wire logic processor_hot_out_n
);
	int low_r;
	int low_nxt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	sequence s_hit_rd;
		clk_en && reg_req.rd_en && reg_req.addr == PHSP_STATUS_ADDR;
	endsequence
	sequence s_miss_rd;
		clk_en && reg_req.rd_en && reg_req.addr != PHSP_STATUS_ADDR;
	endsequence
	// length of the current low stretch of the pin
	always_comb begin
		low_nxt = processor_hot_out_n ? 0 : low_r + 1;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_r <= 0;
		end else begin
			low_r <= low_nxt;
		end
	end
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	a_reset_value: assert property ($rose(rst_n) |-> reg_rd_data == PHSP_STATUS_RST)
		else $error("status not at reset value after reset");
	a_reserved_one: assert property (s_hit_rd |=> reg_rd_data[15])
		else $error("top status bit read as zero");
	a_unmapped_zero: assert property (s_miss_rd |=> reg_rd_data == 16'h0000)
		else $error("unmapped read not zero");
	a_data_stands: assert property (!reg_req.rd_en |=> $stable(reg_rd_data))
		else $error("read data changed without a read");
	a_min_width: assert property ($rose(processor_hot_out_n) |-> low_r >= W0_CYC)
		else $error("low pulse shorter than minimum");
	a_trig_low: assert property ((clk_en && |trig_pins) [*5] |-> !processor_hot_out_n)
		else $error("trigger did not drive pin low");
	a_mode_follows: assert property (clk_en && !peak_assist_req |=> !peak_assist_mode)
		else $error("mode stayed on without request");
	a_exit_low: assert property (clk_en && peak_assist_mode && !peak_assist_req
		|-> ##[1:4] !processor_hot_out_n)
		else $error("mode exit did not drive pin low");
endmodule : phsp_status_properties

bind phsp_status phsp_status_properties #(.W0_CYC(W0_CYC)) u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(reg_req),
	.reg_rd_data(reg_rd_data), .trig_pins(trig_pins), .peak_assist_req(peak_assist_req),
	.peak_assist_mode(peak_assist_mode), .processor_hot_out_n(processor_hot_out_n)
);

// >>> phsp_host_model.sv
// host model that reads and writes the status register
`timescale 1ns/1ps
module phsp_host_model
	import phsp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [15:0] reg_rd_data,
	output phsp_req_t reg_req
);
	initial begin
		reg_req = '0;
	end
	// released lines flip so that a stale value never passes for a live one
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_req.addr <= a;
		reg_req.wr_data <= d;
		reg_req.wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_req.wr_en <= 1'b0;
		reg_req.addr <= ~a;
		reg_req.wr_data <= ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_req.addr <= a;
		reg_req.rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_req.rd_en <= 1'b0;
		reg_req.addr <= ~a;
		@(posedge sys_clk);
		d = reg_rd_data;
		reg_req.rd_done <= 1'b1;
		@(posedge sys_clk);
		reg_req.rd_done <= 1'b0;
	endtask : rd
endmodule : phsp_host_model

// >>> test_processor_hot_status_pulse.sv
// self-checking bench for the processor-hot status block
`timescale 1ns/1ps
module test_processor_hot_status_pulse
	import phsp_pkg::*;
();
	localparam int W0 = 5;
	localparam int W1 = 10;
	localparam logic [7:0] RA = PHSP_STATUS_ADDR;
	logic sys_clk;
	logic rst_n;
	logic en;
	phsp_req_t reg_req;
	logic [15:0] reg_rd_data;
	phsp_trig_t trig_pins;
	phsp_fault_t fault_pins;
	logic vin_pin;
	logic thermal_shutdown_flag_pin;
	logic prof_en;
	logic pa_req;
	logic ld_try;
	logic ld_fail;
	logic pa_mode;
	logic hot_n;
	logic [15:0] rdv;
	int miscompares;
	int cmp_count;
	int n;
	// short counts keep the run small
	phsp_status #(.W0_CYC(W0), .W1_CYC(W1), .W2_CYC(20), .W3_CYC(40)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en), .reg_req(reg_req),
		.reg_rd_data(reg_rd_data), .trig_pins(trig_pins), .input_voltage_limit_pin(vin_pin),
		.thermal_shutdown_pin(thermal_shutdown_flag_pin), .fault_pins(fault_pins),
		.input_voltage_profile_en(prof_en), .peak_assist_req(pa_req),
		.vap_load_attempt(ld_try), .vap_load_fail(ld_fail), .peak_assist_mode(pa_mode),
		.processor_hot_out_n(hot_n)
	);
	phsp_host_model u_host (.sys_clk(sys_clk), .reg_rd_data(reg_rd_data), .reg_req(reg_req));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	task wr(input logic [15:0] d);
		u_host.wr(RA, d);
	endtask : wr
	task rdchk(input logic [15:0] e);
		u_host.rd(RA, rdv);
		chk("status", e, rdv);
	endtask : rdchk
	task give_verdict();
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_regs();
		rdchk(16'hB800);
		wr(16'h7FFF);
		rdchk(16'hF800);
		u_host.rd(8'h22, rdv);
		chk("unmapped", 16'h0000, rdv);
		wr(16'h0800);
		rdchk(16'h8800);
	endtask : t_regs
	task t_flags();
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			if (i < 7) trig_pins <= phsp_trig_t'(7'h01 << i);
			else thermal_shutdown_flag_pin <= 1'b1;
			tick(6);
			trig_pins <= '0;
			thermal_shutdown_flag_pin <= 1'b0;
			tick(W0 + 8);
			rdchk(i < 7 ? 16'h8800 | (16'h0001 << i) : 16'h8C00);
			rdchk(16'h8800);
		end
	endtask : t_flags
	task t_width();
		wr(16'h1800);
		trig_pins <= phsp_trig_t'(7'h40);
		tick(6);
		trig_pins <= '0;
		n = 0;
		while (hot_n !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		chk("width", 1, n >= W1 && n < W1 + 8);
		rdchk(16'h9840);
		wr(16'h0800);
	endtask : t_width
	task t_extend();
		wr(16'h4000);
		trig_pins <= phsp_trig_t'(7'h02);
		tick(6);
		trig_pins <= '0;
		tick(W0 * 8);
		chk("held", 0, hot_n);
		wr(16'h4000);
		tick(3);
		chk("released", 1, hot_n);
		wr(16'h0800);
		rdchk(16'h8802);
	endtask : t_extend
	task t_vin();
		prof_en <= 1'b1;
		vin_pin <= 1'b1;
		tick(6);
		vin_pin <= 1'b0;
		tick(W0 * 8);
		chk("vin low", 0, hot_n);
		rdchk(16'h8880);
		wr(16'h0800);
		tick(W0 + 6);
		chk("vin free", 1, hot_n);
		rdchk(16'h8800);
	endtask : t_vin
	task t_exit();
		for (int i = 0; i < 6; i++) begin
			pa_req <= 1'b1;
			tick(4);
			chk("mode on", 1, pa_mode);
			if (i < 5) fault_pins <= phsp_fault_t'(5'h01 << i);
			else pa_req <= 1'b0;
			tick(6);
			chk("mode off", 0, pa_mode);
			chk("exit low", 0, hot_n);
			fault_pins <= '0;
			pa_req <= 1'b0;
			tick(4);
			rdchk(16'h8900);
			wr(16'h0800);
			tick(W0 + 6);
			chk("exit free", 1, hot_n);
		end
	endtask : t_exit
	task t_fail();
		pa_req <= 1'b1;
		tick(4);
		// one success in mid-run restarts the count of failures
		for (int i = 0; i < 14; i++) begin
			ld_try <= 1'b1;
			ld_fail <= (i != 6);
			@(posedge sys_clk);
			ld_try <= 1'b0;
			tick(2);
			chk("fail mode", i < 13, pa_mode);
		end
		rdchk(16'h8A00);
		chk("latched", 0, pa_mode);
		wr(16'h0800);
		tick(3);
		chk("resumed", 1, pa_mode);
	endtask : t_fail
	// a write presented while the enable is low must leave the register untouched
	task t_freeze();
		en <= 1'b0;
		wr(16'h4800);
		en <= 1'b1;
		rdchk(16'h8800);
		wr(16'h1800);
		rdchk(16'h9800);
		wr(16'h0800);
	endtask : t_freeze
	// ---------------------------------------------------------------
	// run
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		rst_n = 1'b0;
		en = 1'b1;
		trig_pins = '0;
		fault_pins = '0;
		vin_pin = 1'b0;
		thermal_shutdown_flag_pin = 1'b0;
		prof_en = 1'b0;
		pa_req = 1'b0;
		ld_try = 1'b0;
		ld_fail = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		tick(8);
		rst_n <= 1'b1;
		t_regs();
		t_flags();
		t_width();
		t_extend();
		t_vin();
		t_exit();
		t_freeze();
		t_fail();
		give_verdict();
	end
	// own loop: the shared tick task must not be entered by two processes at once
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		give_verdict();
	end
endmodule : test_processor_hot_status_pulse
